// *** hw/fmp_params.svh ***
/*
 * Constants for the flash map, protection and unlock controller.
 * Assumes a single 50 MHz clock and a synchronous active-high reset.
 */
`ifndef FMP_PARAMS_SVH
`define FMP_PARAMS_SVH

`define FMP_CMD_DOUBLE      12'hDD4
`define FMP_CMD_BLOCK       12'hAA5
`define FMP_PROT_READ_VALUE 16'hB88B
`define FMP_ERR_OK          8'h00
`define FMP_ERR_PROTECTED   8'h01
`define FMP_ERR_BAD_CMD     8'hFF
`define FMP_BOOT_ACK        8'hD5
`define FMP_SEG0            8'h00
`define FMP_SEG1            8'h01
`define FMP_FLASH_TOP       8'h04
`define FMP_LOW_BLOCK_BIT   15
`define FMP_CMD_HI_MSB      15
`define FMP_CMD_HI_LSB      4
`define FMP_SEG_NIB_MSB     3

`endif

// *** hw/fmp_pkg.sv ***
/*
 * Types for the flash map, protection and unlock controller.
 * Assumes fmp_params.svh supplies the numeric constants.
 */
package fmp_pkg;

   // Where the current instruction was fetched from
   typedef enum logic [1:0] {
      FMP_SRC_FLASH,
      FMP_SRC_EXTERNAL,
      FMP_SRC_INTERNAL_RAM,
      FMP_SRC_EXTENSION_RAM
   } fmp_src_type;

   // Decoded embedded command kind
   typedef enum logic [1:0] {
      FMP_OP_NONE,
      FMP_OP_DOUBLE,
      FMP_OP_BLOCK
   } fmp_op_type;

   // One CPU data access as seen by the controller
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        indirect;
      logic [23:0] addr;
      logic [15:0] wdata;
      fmp_src_type src;
   } fmp_access_type;

   // Command handed to the embedded routine
   typedef struct packed {
      fmp_op_type  op;
      logic [3:0]  segment;
      logic [15:0] first_off;
      logic [15:0] last_off;
      logic [15:0] source;
   } fmp_cmd_type;

endpackage

// *** hw/fmp_flash_ctrl.sv ***
/*
 * Flash map, protection, unlock and boot-loader entry controller.
 * Assumes the CPU presents one decoded data access per cycle, the
 * embedded routine reports completion with a one-cycle pulse, and the
 * serial channel accepts a byte on a valid/ready handshake.
 */
`timescale 1ns/1ps
`include "fmp_params.svh"

module fmp_flash_ctrl (
   input  wire logic                  clock,          // 50 MHz clock
   input  wire logic                  rst,            // Sync reset, hardware or software
   input  wire logic                  hw_reset,       // High when rst comes from hardware
   input  wire logic                  external_access_strap, // Strap level at reset
   input  wire logic                  boot_select_port_bit,  // Loader select, low selects
   input  wire logic                  otp_protect_bit,       // Hidden one-time protect bit
   input  wire logic                  cfg_write,      // System config write strobe
   input  wire logic                  cfg_flash_enable,      // New flash enable value
   input  wire logic                  cfg_remap,      // New low block remap value
   input  wire logic                  cfg_seg_disable,       // New segmentation disable value
   input  wire fmp_pkg::fmp_access_type acc,          // CPU data access
   input  wire logic                  override_active,// Segment override or uninterruptible_sequence running
   input  wire logic [15:0]           cmd_word,       // Command word register
   input  wire logic [15:0]           cmd_first_off,  // First target offset
   input  wire logic [15:0]           cmd_last_off,   // Last target offset
   input  wire logic [15:0]           cmd_source,     // Source address
   input  wire logic                  cmd_done,       // Embedded routine finished
   input  wire logic [15:0]           array_rdata,    // Raw flash array data
   input  wire logic                  ser_ready,      // Serial channel ready
   output logic                       flash_enable_bit,      // Flash enabled
   output logic                       low_block_remap_bit,   // Low block remap
   output logic                       segmentation_disable_bit, // Segmentation disabled
   output logic                       protect_active, // Protection in force
   output logic                       boot_loader_mode,      // Loader mode active
   output logic                       cmd_start,      // Start embedded routine pulse
   output fmp_pkg::fmp_cmd_type       cmd_out,        // Decoded command
   output logic                       cmd_refused,    // Command refused pulse
   output logic [7:0]                 cmd_error,      // Error code of refused command
   output logic [15:0]                read_data,      // Data returned to CPU
   output logic                       read_valid,     // Read data valid pulse
   output logic [23:0]                flash_addr,     // Physical flash address
   output logic                       irq_block,      // Mask interrupts, events, traps
   output logic                       ser_valid,      // Serial byte valid
   output logic [7:0]                 ser_data        // Serial byte
);

   ////////////////////////////////////////////////////////////////////////
   logic        in_flash;
   logic [23:0] phys_addr;
   logic        unlock_armed_reg;
   logic [23:0] unlock_addr_reg;
   logic        deprot_reg;
   logic        ack_sent_reg;
   logic        strap_pending_reg;
   logic [11:0] cmd_hi;
   logic        unlock_hit;
   logic        from_flash;

   assign from_flash = (acc.src == fmp_pkg::FMP_SRC_FLASH);
   assign cmd_hi     = cmd_word[`FMP_CMD_HI_MSB:`FMP_CMD_HI_LSB];

   // Flash window decode; low 32 KB sits in segment 0 or 1 per remap
   always_comb begin
      in_flash  = 1'b0;
      phys_addr = acc.addr;
      if (flash_enable_bit) begin
         if (acc.addr[23:16] == `FMP_SEG0 && !acc.addr[`FMP_LOW_BLOCK_BIT] && !low_block_remap_bit)
            in_flash = 1'b1;
         else if (acc.addr[23:16] == `FMP_SEG1 && !acc.addr[`FMP_LOW_BLOCK_BIT] && low_block_remap_bit) begin
            in_flash  = 1'b1;
            phys_addr = {8'h00, acc.addr[15:0]};
         end else if (acc.addr[23:16] >= `FMP_SEG1 && acc.addr[23:16] <= `FMP_FLASH_TOP
                      && !(acc.addr[23:16] == `FMP_SEG1 && !acc.addr[`FMP_LOW_BLOCK_BIT]))
            in_flash = 1'b1; // Upper flash never moves
      end
   end

   // Second unlock write must match the first, indirect, even, in flash
   assign unlock_hit = acc.valid && acc.write && acc.indirect && unlock_armed_reg
                       && acc.addr == unlock_addr_reg && in_flash && !acc.addr[0];

   ////////////////////////////////////////////////////////////////////////
   // Strap capture one cycle after release; async-free, so it is clocked
   always_ff @(posedge clock) begin
      if (rst)
         strap_pending_reg <= 1'b1;
      else
         strap_pending_reg <= 1'b0;
   end

   // System configuration bits
   always_ff @(posedge clock) begin
      if (rst) begin
         flash_enable_bit         <= 1'b0;
         low_block_remap_bit      <= 1'b0;
         segmentation_disable_bit <= 1'b1;
      end else if (strap_pending_reg) begin
         flash_enable_bit <= external_access_strap;
      end else if (cfg_write) begin
         flash_enable_bit         <= cfg_flash_enable;
         low_block_remap_bit      <= cfg_remap;
         segmentation_disable_bit <= cfg_seg_disable;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Unlock sequencer: every access reloads the arm; only a direct even write in flash arms it
   always_ff @(posedge clock) begin
      if (rst) begin
         unlock_armed_reg <= 1'b0;
         unlock_addr_reg  <= 24'h000000;
      end else if (acc.valid) begin
         unlock_armed_reg <= acc.write && !acc.indirect && in_flash && !acc.addr[0];
         unlock_addr_reg  <= acc.addr;
      end
   end

   // Override blocks interrupts across the two unlock writes
   always_ff @(posedge clock) begin
      if (rst)
         irq_block <= 1'b0;
      else
         irq_block <= override_active || unlock_armed_reg;
   end

   ////////////////////////////////////////////////////////////////////////
   // Temporary de-protection; cleared on completion so state follows the OTP bit
   always_ff @(posedge clock) begin
      if (rst)
         deprot_reg <= 1'b0;
      else if (acc.valid && acc.write && from_flash && in_flash && !acc.addr[0]
               && acc.wdata == 16'h0000 && !unlock_hit)
         deprot_reg <= 1'b1;
      else if (cmd_done)
         deprot_reg <= 1'b0;
   end

   // Protection flag; a deprotect write wins over a completion in the same cycle
   always_ff @(posedge clock) begin
      if (rst)
         protect_active <= otp_protect_bit;
      else if (acc.valid && acc.write && from_flash && in_flash && !acc.addr[0]
               && acc.wdata == 16'h0000 && !unlock_hit)
         protect_active <= 1'b0;
      else if (cmd_done)
         protect_active <= otp_protect_bit;
      else
         protect_active <= otp_protect_bit && !deprot_reg;
   end

   ////////////////////////////////////////////////////////////////////////
   // Command decode and launch
   always_ff @(posedge clock) begin
      if (rst) begin
         cmd_start   <= 1'b0;
         cmd_refused <= 1'b0;
         cmd_error   <= `FMP_ERR_OK;
         cmd_out     <= '0;
      end else begin
         cmd_start   <= 1'b0;
         cmd_refused <= 1'b0;
         if (unlock_hit) begin
            cmd_out.segment   <= cmd_word[`FMP_SEG_NIB_MSB:0];
            cmd_out.first_off <= cmd_first_off;
            cmd_out.last_off  <= cmd_last_off;
            cmd_out.source    <= cmd_source;
            if (protect_active) begin
               cmd_refused <= 1'b1;
               cmd_error   <= `FMP_ERR_PROTECTED;
               cmd_out.op  <= fmp_pkg::FMP_OP_NONE;
            end else if (cmd_hi == `FMP_CMD_DOUBLE) begin
               cmd_start  <= 1'b1;
               cmd_error  <= `FMP_ERR_OK;
               cmd_out.op <= fmp_pkg::FMP_OP_DOUBLE;
            end else if (cmd_hi == `FMP_CMD_BLOCK) begin
               cmd_start  <= 1'b1;
               cmd_error  <= `FMP_ERR_OK;
               cmd_out.op <= fmp_pkg::FMP_OP_BLOCK;
            end else begin
               cmd_refused <= 1'b1;
               cmd_error   <= `FMP_ERR_BAD_CMD;
               cmd_out.op  <= fmp_pkg::FMP_OP_NONE;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path; protected reads from non-flash code get the fixed pattern
   always_ff @(posedge clock) begin
      if (rst) begin
         read_valid <= 1'b0;
         read_data  <= 16'h0000;
         flash_addr <= 24'h000000;
      end else begin
         read_valid <= acc.valid && !acc.write && in_flash;
         flash_addr <= phys_addr;
         if (protect_active && !from_flash)
            read_data <= `FMP_PROT_READ_VALUE;
         else
            read_data <= array_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Remembers whether the reset now ending was a hardware one
   logic hw_reset_seen_reg;

   // Loader mode: only a hardware reset samples the select; soft reset exits
   always_ff @(posedge clock) begin
      if (rst)
         boot_loader_mode <= 1'b0;
      else if (strap_pending_reg)
         boot_loader_mode <= hw_reset_seen_reg && !boot_select_port_bit;
   end

   // Latched while rst is held, so the select is sampled at the first edge after release
   always_ff @(posedge clock) begin
      if (rst)
         hw_reset_seen_reg <= hw_reset;
      else if (strap_pending_reg)
         hw_reset_seen_reg <= 1'b0;
      else
         hw_reset_seen_reg <= hw_reset_seen_reg;
   end

   // Acknowledge byte sent once per loader entry
   always_ff @(posedge clock) begin
      if (rst) begin
         ack_sent_reg <= 1'b0;
         ser_valid    <= 1'b0;
         ser_data     <= 8'h00;
      end else if (boot_loader_mode && !ack_sent_reg) begin
         ser_valid <= 1'b1;
         ser_data  <= `FMP_BOOT_ACK;
         if (ser_valid && ser_ready) begin
            ser_valid    <= 1'b0;
            ack_sent_reg <= 1'b1;
         end
      end else begin
         ser_valid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   a_unlock_launch: assert property (@(posedge clock) disable iff (rst)
      unlock_hit && !protect_active && cmd_hi == `FMP_CMD_DOUBLE |=> cmd_start && cmd_out.op == fmp_pkg::FMP_OP_DOUBLE)
      else $error("double command not launched");
   a_block_launch: assert property (@(posedge clock) disable iff (rst)
      unlock_hit && !protect_active && cmd_hi == `FMP_CMD_BLOCK |=> cmd_start && cmd_out.op == fmp_pkg::FMP_OP_BLOCK)
      else $error("block command not launched");
   a_start_needs_unlock: assert property (@(posedge clock) disable iff (rst)
      cmd_start |-> $past(unlock_hit) && $past(unlock_armed_reg))
      else $error("command started without unlock");
   a_protect_refuse: assert property (@(posedge clock) disable iff (rst)
      unlock_hit && protect_active |=> cmd_refused && cmd_error == `FMP_ERR_PROTECTED && !cmd_start)
      else $error("protected command not refused");
   a_protect_pattern: assert property (@(posedge clock) disable iff (rst)
      acc.valid && !acc.write && in_flash && protect_active && !from_flash
      |=> read_valid && read_data == `FMP_PROT_READ_VALUE)
      else $error("protected read leaked data");
   a_flash_read_ok: assert property (@(posedge clock) disable iff (rst)
      acc.valid && !acc.write && in_flash && from_flash |=> read_data == $past(array_rdata))
      else $error("flash code read blocked");
   a_done_rearm: assert property (@(posedge clock) disable iff (rst)
      cmd_done && otp_protect_bit && !(acc.valid && acc.write) |=> protect_active)
      else $error("protection not re-armed");
   a_strap_load: assert property (@(posedge clock) disable iff (rst)
      strap_pending_reg |=> flash_enable_bit == $past(external_access_strap))
      else $error("strap not loaded");
   a_ack_byte: assert property (@(posedge clock) disable iff (rst)
      ser_valid |-> ser_data == `FMP_BOOT_ACK && boot_loader_mode)
      else $error("wrong acknowledge byte");

endmodule

// *** verif/fmp_far_model.sv ***
/*
 * Far-side model: flash array word, embedded routine timing, serial host.
 * Assumes cmd_start is a one-cycle pulse and ser_valid holds until taken.
 */
`timescale 1ns/1ps

module fmp_far_model #(
   parameter logic [15:0] ARRAY_WORD = 16'h3C3C, // Arbitrary array content
   parameter int          DONE_DELAY = 5         // Routine run time in cycles
) (
   input  wire logic   clock,              // 50 MHz clock
   input  wire logic   cmd_start,          // Routine start pulse
   input  wire logic   ser_valid,          // Serial byte offered
   output logic        cmd_done = 1'b0,    // Routine finished pulse
   output logic [15:0] array_rdata,        // Array word
   output logic        ser_ready = 1'b0    // Host takes byte
);
   int run_count = 0;
   int ser_wait  = 0;

   // One fixed word keeps expectations simple; no contents are stored
   assign array_rdata = ARRAY_WORD;

   // Routine ends a fixed time after its start
   always @(posedge clock) begin
      cmd_done <= (run_count == 1);
      if (cmd_start)
         run_count <= DONE_DELAY;
      else if (run_count != 0)
         run_count <= run_count - 1;
   end

   // Host stalls a few cycles so the held byte is exercised
   always @(posedge clock) begin
      ser_wait  <= ser_valid ? ser_wait + 1 : 0;
      ser_ready <= ser_valid && (ser_wait >= 2);
   end
endmodule

// *** verif/test_fmp_flash_ctrl.sv ***
/*
 * Testbench for the flash map, protection and unlock controller.
 * Assumes fmp_pkg and fmp_params.svh are compiled first.
 */
`timescale 1ns/1ps
`include "fmp_params.svh"

module test_fmp_flash_ctrl;
   localparam logic [23:0] FA = 24'h018000; // Even, outside remapped block
   localparam logic [15:0] AW = 16'h3C3C;   // Array word of far model
   logic clock = 1'b0, rst = 1'b1, hw_reset = 1'b1, external_access_strap = 1'b1;
   logic boot_select_port_bit = 1'b1, otp_protect_bit = 1'b0, override_active = 1'b0;
   logic cfg_write = 1'b0, cfg_flash_enable = 1'b0, cfg_remap = 1'b0, cfg_seg_disable = 1'b0;
   logic [15:0] cmd_word = 16'h0000, array_rdata, read_data;
   logic cmd_done, ser_ready, flash_enable_bit, low_block_remap_bit, segmentation_disable_bit;
   logic protect_active, boot_loader_mode, cmd_start, cmd_refused, read_valid, irq_block, ser_valid;
   logic [7:0] cmd_error, ser_data;
   logic [23:0] flash_addr, a0;
   fmp_pkg::fmp_access_type acc = '0;
   fmp_pkg::fmp_cmd_type cmd_out;
   int n_mismatch = 0, check_count = 0;
   bit hit;

   // Clock at 50 MHz
   always #10 clock = ~clock;

   fmp_flash_ctrl DUT (.clock(clock), .rst(rst), .hw_reset(hw_reset),
      .external_access_strap(external_access_strap), .boot_select_port_bit(boot_select_port_bit),
      .otp_protect_bit(otp_protect_bit), .cfg_write(cfg_write), .cfg_flash_enable(cfg_flash_enable),
      .cfg_remap(cfg_remap), .cfg_seg_disable(cfg_seg_disable), .acc(acc),
      .override_active(override_active), .cmd_word(cmd_word), .cmd_first_off(16'h9000),
      .cmd_last_off(16'h9FFE), .cmd_source(16'h9000), .cmd_done(cmd_done), .array_rdata(array_rdata),
      .ser_ready(ser_ready), .flash_enable_bit(flash_enable_bit), .low_block_remap_bit(low_block_remap_bit),
      .segmentation_disable_bit(segmentation_disable_bit), .protect_active(protect_active),
      .boot_loader_mode(boot_loader_mode), .cmd_start(cmd_start), .cmd_out(cmd_out),
      .cmd_refused(cmd_refused), .cmd_error(cmd_error), .read_data(read_data), .read_valid(read_valid),
      .flash_addr(flash_addr), .irq_block(irq_block), .ser_valid(ser_valid), .ser_data(ser_data));

   fmp_far_model #(.ARRAY_WORD(AW), .DONE_DELAY(5)) far (.clock(clock), .cmd_start(cmd_start),
      .ser_valid(ser_valid), .cmd_done(cmd_done), .array_rdata(array_rdata), .ser_ready(ser_ready));

   ////////////////////////////////////////////////////////////////////////////
   // Reporting
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   // Bounded wait: 0 command answer, 1 read data, 2 serial byte
   task automatic wait_for(input int which, input bit must, output bit found);
      found = 1'b0;
      for (int i = 0; i < 8 && !found; i++) begin
         found = (which == 0) ? (cmd_start === 1'b1 || cmd_refused === 1'b1) :
                 (which == 1) ? (read_valid === 1'b1) : (ser_valid === 1'b1);
         if (!found)
            @(negedge clock);
      end
      if (must && !found) begin
         n_mismatch++;
         $display("CHECK FAILED wait %0d expected 1 seen 0", which);
         close_out();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Access protocol, driven on falling edges
   task automatic do_reset(input logic hw, strap, bsel, otp);
      rst = 1'b1;
      hw_reset = hw;
      external_access_strap = strap;
      boot_select_port_bit = bsel;
      otp_protect_bit = otp;
      repeat (3) @(negedge clock);
      rst = 1'b0;
      repeat (2) @(negedge clock);
   endtask

   task automatic cfg(input logic en, remap, sdis);
      {cfg_write, cfg_flash_enable, cfg_remap, cfg_seg_disable} = {1'b1, en, remap, sdis};
      @(negedge clock);
      cfg_write = 1'b0;
      @(negedge clock);
   endtask

   task automatic acc_op(input logic wr, ind, input logic [23:0] a, input logic [15:0] d,
                         input fmp_pkg::fmp_src_type s);
      acc = '{1'b1, wr, ind, a, d, s};
      @(negedge clock);
   endtask

   task automatic rd(input fmp_pkg::fmp_src_type s, input logic [15:0] e);
      acc_op(1'b0, 1'b0, FA, 16'h0000, s);
      acc.valid = 1'b0;
      wait_for(1, 1'b1, hit);
      chk("read_data", e, read_data);
   endtask

   // Direct then indirect write of the same address, even or odd, under an override
   task automatic try_cmd(input logic [15:0] w, input logic [23:0] a, input logic st,
                          input fmp_pkg::fmp_op_type op, input logic [7:0] err);
      cmd_word = w;
      override_active = 1'b1;
      acc_op(1'b1, 1'b0, a, a[15:0], fmp_pkg::FMP_SRC_INTERNAL_RAM);
      acc_op(1'b1, 1'b1, a, a[15:0], fmp_pkg::FMP_SRC_INTERNAL_RAM);
      acc.valid = 1'b0;
      chk("irq_block", 1'b1, irq_block);
      override_active = 1'b0;
      wait_for(0, a[0] == 1'b0, hit);
      chk("cmd_start", st, cmd_start);
      if (st) begin
         chk("cmd_op", op, cmd_out.op);
         chk("cmd_seg", w[3:0], cmd_out.segment);
      end else if (a[0] == 1'b0)
         chk("cmd_error", err, cmd_error);
      repeat (8) @(negedge clock);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      @(negedge clock);
      do_reset(1'b1, 1'b1, 1'b1, 1'b0);
      chk("flash_enable", 1'b1, flash_enable_bit);
      chk("seg_disable", 1'b1, segmentation_disable_bit);
      chk("protect", 1'b0, protect_active);
      chk("loader", 1'b0, boot_loader_mode);
      cfg(1'b0, 1'b0, 1'b1);
      chk("flash_enable", 1'b0, flash_enable_bit);
      cfg(1'b1, 1'b0, 1'b0);
      chk("flash_enable", 1'b1, flash_enable_bit);
      rd(fmp_pkg::FMP_SRC_EXTERNAL, AW);
      a0 = flash_addr;
      cfg(1'b1, 1'b1, 1'b0);
      chk("remap", 1'b1, low_block_remap_bit);
      rd(fmp_pkg::FMP_SRC_EXTERNAL, AW);
      chk("flash_addr", a0, flash_addr);
      try_cmd(16'hDD41, FA, 1'b1, fmp_pkg::FMP_OP_DOUBLE, 8'h00);
      try_cmd(16'hAA52, FA, 1'b1, fmp_pkg::FMP_OP_BLOCK, 8'h00);
      try_cmd(16'h1234, FA, 1'b0, fmp_pkg::FMP_OP_NONE, `FMP_ERR_BAD_CMD);
      try_cmd(16'hDD41, FA + 24'h1, 1'b0, fmp_pkg::FMP_OP_NONE, 8'h00);
      // Protected part
      do_reset(1'b1, 1'b1, 1'b1, 1'b1);
      chk("protect", 1'b1, protect_active);
      rd(fmp_pkg::FMP_SRC_EXTERNAL, `FMP_PROT_READ_VALUE);
      rd(fmp_pkg::FMP_SRC_EXTENSION_RAM, `FMP_PROT_READ_VALUE);
      rd(fmp_pkg::FMP_SRC_FLASH, AW);
      try_cmd(16'hDD41, FA, 1'b0, fmp_pkg::FMP_OP_NONE, `FMP_ERR_PROTECTED);
      acc_op(1'b1, 1'b0, FA, 16'h0000, fmp_pkg::FMP_SRC_INTERNAL_RAM);
      acc.valid = 1'b0;
      @(negedge clock);
      chk("protect", 1'b1, protect_active);
      acc_op(1'b1, 1'b0, FA, 16'h0000, fmp_pkg::FMP_SRC_FLASH);
      acc.valid = 1'b0;
      @(negedge clock);
      chk("protect", 1'b0, protect_active);
      rd(fmp_pkg::FMP_SRC_INTERNAL_RAM, AW);
      try_cmd(16'hAA51, FA, 1'b1, fmp_pkg::FMP_OP_BLOCK, 8'h00);
      chk("protect", 1'b1, protect_active);
      // Loader entry and exit
      do_reset(1'b1, 1'b1, 1'b0, 1'b0);
      chk("loader", 1'b1, boot_loader_mode);
      wait_for(2, 1'b1, hit);
      chk("ser_data", `FMP_BOOT_ACK, ser_data);
      do_reset(1'b0, 1'b1, 1'b0, 1'b0);
      chk("loader", 1'b0, boot_loader_mode);
      close_out();
   end
endmodule
